//--- design/cpldlb_pkg.sv
// Package for the programmable logic block: sizes, codes and reset values.
// Assumes every file of the block imports it whole.
package cpldlb_pkg;

   // Sizes of one logic block.
   localparam int NUM_INPUTS     = 36;
   localparam int NUM_LITERALS   = 2 * NUM_INPUTS;
   localparam int NUM_MACROCELLS = 16;
   localparam int PAL_TERMS      = 5;
   localparam int PLA_TERMS      = 32;
   localparam int NUM_CT         = 6;
   localparam int MAX_TERMS      = PAL_TERMS + PLA_TERMS;

   // Control term roles.
   localparam int CT_PRESET = 0;
   localparam int CT_RESET  = 1;
   localparam int CT_CLK_A  = 2;
   localparam int CT_CLK_B  = 3;

   // Output enable source codes.
   localparam logic [2:0] OE_OFF = 3'h0;
   localparam logic [2:0] OE_ON  = 3'h1;
   localparam logic [2:0] OE_CT2 = 3'h2;
   localparam logic [2:0] OE_CT3 = 3'h3;
   localparam logic [2:0] OE_CT4 = 3'h4;
   localparam logic [2:0] OE_CT5 = 3'h5;

   // Values after reset.
   localparam logic Q_RESET    = 1'h0;
   localparam logic CLK_PREV_RESET = 1'h0;

   // Macrocell storage mode.
   typedef enum logic [2:0] {
      MC_COMB = 3'h1,
      MC_DFF  = 3'h2,
      MC_TFF  = 3'h4
   } cpldlb_mode_t;

   // Macrocell clock source.
   typedef enum logic [3:0] {
      CS_GLOBAL0 = 4'h1,
      CS_GLOBAL1 = 4'h2,
      CS_CT2     = 4'h4,
      CS_CT3     = 4'h8
   } cpldlb_clksel_t;

endpackage

//--- design/cpldlb_macrocell.sv
// One macrocell: D, T or combinational, with clock select and async set/clear.
// Assumes clock edges arrive as one-cycle strobes from the enclosing block.
`timescale 1ns/10ps
`default_nettype none

module cpldlb_macrocell
   import cpldlb_pkg::*;
(
   // Clock and reset.
   input  wire logic           clock,
   input  wire logic           sys_rst,
   // Logic input and configuration.
   input  wire logic           sum_in,
   input  wire cpldlb_mode_t   mode,
   input  wire cpldlb_clksel_t clk_sel,
   input  wire logic           clk_falling,
   input  wire logic           async_en,
   // Clock strobes and control terms.
   input  wire logic [1:0]     glob_rise,
   input  wire logic [1:0]     glob_fall,
   input  wire logic [1:0]     ct_rise,
   input  wire logic           preset,
   input  wire logic           reset,
   // Macrocell output.
   output logic                q_out
);

   logic       q;
   logic       next_q;
   logic       stored;
   logic [1:0] glob_edge;
   logic       tick;
   logic       force_rst;
   logic       force_set;

   // Selected clock strobe; global clocks take either edge.
   assign glob_edge = clk_falling ? glob_fall : glob_rise; // R5
   assign tick = (clk_sel == CS_GLOBAL0 && glob_edge[0])
              || (clk_sel == CS_GLOBAL1 && glob_edge[1])
              || (clk_sel == CS_CT2 && ct_rise[0])
              || (clk_sel == CS_CT3 && ct_rise[1]); // R2
   // Async controls; reset wins over preset, both gated per cell.
   assign force_rst = async_en && reset; // R8 R10
   assign force_set = async_en && preset && !reset; // R8 R10

   // Value the storage element takes on its clock strobe.
   always_comb begin
      case (mode)
         MC_TFF:  stored = q ^ sum_in; // R21
         MC_DFF:  stored = sum_in; // R1
         default: stored = q;
      endcase
   end

   // Next state with async controls overriding the clock.
   assign next_q = force_rst ? 1'h0 :
                   force_set ? 1'h1 :
                   tick      ? stored : q;

   // Storage flip-flop, cleared at power-up.
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         q <= Q_RESET; // R9
      end else begin
         q <= next_q;
      end
   end

   // Output shows async controls at once; combinational mode bypasses.
   assign q_out = (mode == MC_COMB) ? sum_in :
                  force_rst ? 1'h0 : force_set ? 1'h1 : q; // R1 R8

   default clocking cb @(posedge clock); endclocking
   default disable iff (sys_rst);

   property p_comb;
      mode == MC_COMB |-> q_out == sum_in;
   endproperty
   a_comb: assert property (p_comb) // R1
      else $error("Combinational macrocell does not follow its input.");

   property p_dff;
      (mode == MC_DFF && tick && !force_rst && !force_set)
         |=> q == $past(sum_in);
   endproperty
   a_dff: assert property (p_dff) // R1
      else $error("D flip-flop did not capture its input.");

   property p_toggle;
      (mode == MC_TFF && tick && !force_rst && !force_set)
         |=> q == ($past(q) ^ $past(sum_in));
   endproperty
   a_toggle: assert property (p_toggle) // R21
      else $error("T flip-flop did not toggle or hold correctly.");

   property p_async;
      (async_en && reset && mode != MC_COMB) |-> q_out == 1'h0 ##1 q == 1'h0;
   endproperty
   a_async: assert property (p_async) // R8
      else $error("Async reset did not clear the macrocell.");

   property p_async_off;
      (!async_en && (preset || reset) && !tick) |=> $stable(q);
   endproperty
   a_async_off: assert property (p_async_off) // R10
      else $error("Disabled async control changed the flip-flop.");

   property p_edge_sel;
      (clk_sel == CS_GLOBAL0 && clk_falling && !glob_fall[0]
         && !async_en) |=> $stable(q);
   endproperty
   a_edge_sel: assert property (p_edge_sel) // R5
      else $error("Flip-flop moved without its selected edge.");

   property p_por;
      disable iff (1'b0) sys_rst |=> q == Q_RESET;
   endproperty
   a_por: assert property (p_por) // R9
      else $error("Power-up reset did not clear the flip-flop.");

   c_toggle: cover property (mode == MC_TFF && tick && sum_in);
   c_dff: cover property (mode == MC_DFF && tick && clk_sel == CS_CT2);

endmodule

`default_nettype wire

//--- design/cpldlb_block.sv
// Logic block: control terms, PAL and PLA arrays, 16 macrocells, pins.
// Assumes configuration ports are static and all inputs sync to clock.
`timescale 1ns/10ps
`default_nettype none

// Contract
// R1: Each macrocell is a D flip-flop, T flip-flop or combinational path.
// R2: Flip-flop clock is one of two global clocks or two control terms.
// R3: First global clock comes only from outside the block.
// R4: Second global clock is external or driven by a macrocell equation.
// R5: Each flip-flop may use rising or falling edge of a global clock.
// R6: The two clock control terms are sum or product over 36 inputs.
// R7: Six control terms, each sum or product, shared by all 16 cells.
// R8: Control terms zero and one preset and clear flip-flops at once.
// R9: Power-up clears every macrocell flip-flop to zero.
// R10: Async preset and clear can be disabled per macrocell.
// R11: Control terms two and three serve as clocks and output enables.
// R12: Control terms four and five serve as output enables too.
// R13: An output buffer may be always enabled or always disabled.
// R14: Enabled global tristate with pin low floats every output.
// R15: Each cell feeds back its own output and its pin value.
// R16: A pin used as input is tristated and read through pin feedback.
// R17: Five dedicated terms per cell, up to 37 with shared terms.
// R18: Shared array of 32 terms, each assignable to any of 16 cells.
// R19: One shared term may feed several cells at the same time.
// R20: Block takes 36 inputs and returns 32 feedback signals.
// R21: T flip-flop toggles on its edge when input is high, else holds.
module cpldlb_block
   import cpldlb_pkg::*;
#(
   parameter int N_IN  = NUM_INPUTS,
   parameter int N_MC  = NUM_MACROCELLS,
   parameter int N_PAL = PAL_TERMS,
   parameter int N_PLA = PLA_TERMS
)(
   // Clock and reset.
   input  wire logic                                 clock,
   input  wire logic                                 sys_rst,
   // Global clocks and tristate pin.
   input  wire logic                                 sync_global_clock,
   input  wire logic                                 dual_mode_global_clock,
   input  wire logic                                 global_tristate_pin,
   // Inputs from the interconnect.
   input  wire logic [N_IN-1:0]                      central_interconnect_array,
   // Control term configuration.
   input  wire logic [NUM_CT-1:0][2*N_IN-1:0]        ct_mask,
   input  wire logic [NUM_CT-1:0]                    ct_is_sum,
   // Product term arrays.
   input  wire logic [N_MC-1:0][N_PAL-1:0][2*N_IN-1:0] pal_mask,
   input  wire logic [N_PLA-1:0][2*N_IN-1:0]         pla_mask,
   input  wire logic [N_MC-1:0][N_PLA-1:0]           pla_or_mask,
   // Per-macrocell configuration.
   input  wire cpldlb_mode_t   [N_MC-1:0]            mc_mode,
   input  wire cpldlb_clksel_t [N_MC-1:0]            mc_clk_sel,
   input  wire logic [N_MC-1:0]                      mc_clk_falling,
   input  wire logic [N_MC-1:0]                      mc_async_en,
   input  wire logic [N_MC-1:0][2:0]                 mc_oe_sel,
   // Global clock and tristate configuration.
   input  wire logic                                 dual_mode_global_clock_internal,
   input  wire logic [3:0]                           dual_mode_global_clock_mc_index,
   input  wire logic                                 gts_enable,
   // Pins.
   input  wire logic [N_MC-1:0]                      pad_in,
   output logic [N_MC-1:0]                           pad_out,
   output logic [N_MC-1:0]                           pad_oe,
   // Feedback to the interconnect.
   output logic [N_MC-1:0]                           mc_feedback,
   output logic [N_MC-1:0]                           pin_feedback
);

   logic [2*N_IN-1:0]  lits;
   logic [NUM_CT-1:0]  ct_val;
   logic [N_PLA-1:0]   pla_term;
   logic [N_MC-1:0]    mc_sum;
   logic [N_MC-1:0]    mc_out;
   logic [N_MC-1:0]    base_oe;
   logic               dual_mode_global_clock_level;
   logic [1:0]         glob_level;
   logic [1:0]         glob_prev;
   logic [1:0]         glob_rise;
   logic [1:0]         glob_fall;
   logic [1:0]         ctclk_prev;
   logic [1:0]         ct_rise;
   logic               gts_active;

   // Product of selected literals; an empty mask gives an unused zero term.
   function automatic logic and_term(input logic [2*N_IN-1:0] l,
                                     input logic [2*N_IN-1:0] m);
      and_term = (|m) && (&(l | ~m));
   endfunction

   // Sum of selected literals.
   function automatic logic or_term(input logic [2*N_IN-1:0] l,
                                    input logic [2*N_IN-1:0] m);
      or_term = |(l & m);
   endfunction

   // True and complement of every interconnect input.
   assign lits = {~central_interconnect_array,
                  central_interconnect_array}; // R20

   // Six shared control terms, each a sum or a product.
   generate
      for (genvar c = 0; c < NUM_CT; c++) begin : g_ct
         assign ct_val[c] = ct_is_sum[c] ? or_term(lits, ct_mask[c])
                                         : and_term(lits, ct_mask[c]); // R7 R6
      end
   endgenerate

   // Shared array terms, each usable by any macrocell.
   generate
      for (genvar p = 0; p < N_PLA; p++) begin : g_pla
         assign pla_term[p] = and_term(lits, pla_mask[p]); // R18
      end
   endgenerate

   // Second global clock from the pin or from a macrocell equation.
   assign dual_mode_global_clock_level = dual_mode_global_clock_internal ? mc_out[dual_mode_global_clock_mc_index]
                                     : dual_mode_global_clock; // R4
   // First global clock has no internal source.
   assign glob_level = {dual_mode_global_clock_level, sync_global_clock}; // R3

   // Edge strobes for the global clocks and the clock control terms.
   assign glob_rise = glob_level & ~glob_prev;
   assign glob_fall = ~glob_level & glob_prev; // R5
   // Control-term clocks act on their rising edge only.
   assign ct_rise = ct_val[CT_CLK_B:CT_CLK_A] & ~ctclk_prev; // R11

   // Previous levels of every clock source.
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         glob_prev  <= {2{CLK_PREV_RESET}};
         ctclk_prev <= {2{CLK_PREV_RESET}};
      end else begin
         glob_prev  <= glob_level;
         ctclk_prev <= ct_val[CT_CLK_B:CT_CLK_A];
      end
   end

   // Global tristate is active while enabled and the pin is low.
   assign gts_active = gts_enable && !global_tristate_pin; // R14

   // Per-macrocell sum, storage, enable and feedback.
   generate
      for (genvar m = 0; m < N_MC; m++) begin : g_mc
         logic [N_PAL-1:0] pal_term;
         logic [7:0]       oe_src;

         for (genvar t = 0; t < N_PAL; t++) begin : g_pal
            assign pal_term[t] = and_term(lits, pal_mask[m][t]); // R17
         end

         // Dedicated terms plus any shared terms, even shared by others.
         assign mc_sum[m] = (|pal_term)
                         || (|(pla_term & pla_or_mask[m])); // R17 R19

         cpldlb_macrocell u_mc (
            .clock       (clock),
            .sys_rst     (sys_rst),
            .sum_in      (mc_sum[m]),
            .mode        (mc_mode[m]),
            .clk_sel     (mc_clk_sel[m]),
            .clk_falling (mc_clk_falling[m]),
            .async_en    (mc_async_en[m]),
            .glob_rise   (glob_rise),
            .glob_fall   (glob_fall),
            .ct_rise     (ct_rise),
            .preset      (ct_val[CT_PRESET]),
            .reset       (ct_val[CT_RESET]),
            .q_out       (mc_out[m])
         );

         // Enable sources: off, on, then control terms two to five.
         assign oe_src = {2'h0, ct_val[5:2], 1'h1, 1'h0}; // R11 R12 R13
         assign base_oe[m] = oe_src[mc_oe_sel[m]];
      end
   endgenerate

   // Pin drive and the two feedback paths.
   assign pad_out      = mc_out;
   assign pad_oe       = gts_active ? '0 : base_oe; // R14 R16
   assign mc_feedback  = mc_out; // R15
   assign pin_feedback = pad_in; // R15 R16

   // Checks below run on the block clock and rest during reset.
   default clocking cb @(posedge clock); endclocking
   default disable iff (sys_rst);

   // Global tristate floats every pin at once.
   property p_gts;
      (gts_enable && !global_tristate_pin) |-> pad_oe == '0;
   endproperty
   a_gts: assert property (p_gts) // R14
      else $error("Outputs driven while global tristate is active.");

   // Enables of cell five, which steps through every enable code.
   property p_oe_fixed;
      (mc_oe_sel[5] == OE_OFF |-> !pad_oe[5])
      and ((mc_oe_sel[5] == OE_ON && !gts_active) |-> pad_oe[5]);
   endproperty
   a_oe_fixed: assert property (p_oe_fixed) // R13
      else $error("Fixed output enable not honoured.");

   property p_oe_ct;
      (mc_oe_sel[5] == OE_CT4 && !gts_active) |-> pad_oe[5] == ct_val[4];
   endproperty
   a_oe_ct: assert property (p_oe_ct) // R12
      else $error("Output enable does not follow its control term.");

   // Enable codes for the clock terms, the last term and the spare codes.
   property p_oe_ctclk;
      ((mc_oe_sel[5] == OE_CT2 && !gts_active)
         |-> pad_oe[5] == ct_val[CT_CLK_A])
      and ((mc_oe_sel[5] == OE_CT3 && !gts_active)
         |-> pad_oe[5] == ct_val[CT_CLK_B]);
   endproperty
   a_oe_ctclk: assert property (p_oe_ctclk) // R11
      else $error("Clock control term does not drive the output enable.");

   property p_oe_ct5;
      (mc_oe_sel[5] == OE_CT5 && !gts_active) |-> pad_oe[5] == ct_val[5];
   endproperty
   a_oe_ct5: assert property (p_oe_ct5) // R12
      else $error("Output enable does not follow control term five.");

   property p_oe_spare;
      (mc_oe_sel[5] > OE_CT5) |-> !pad_oe[5];
   endproperty
   a_oe_spare: assert property (p_oe_spare) // R13
      else $error("Spare enable code drove the pin.");

   // Feedback paths mirror the cell output and the pin level.
   property p_feedback;
      pin_feedback == pad_in && mc_feedback == pad_out;
   endproperty
   a_feedback: assert property (p_feedback) // R15
      else $error("Feedback paths do not match macrocell and pin.");

   // A pin set up as an input is released and read back through its pin.
   property p_pin_input;
      (mc_oe_sel[8] == OE_OFF) |-> !pad_oe[8]
         && pin_feedback[8] == pad_in[8] && mc_feedback[8] == mc_out[8];
   endproperty
   a_pin_input: assert property (p_pin_input) // R16
      else $error("Input pin not released or not fed back.");

   // Internal second clock and control-term clock strobes.
   property p_dual_mode_global_clock_int;
      (dual_mode_global_clock_internal && $stable(dual_mode_global_clock_mc_index)
         && mc_out[dual_mode_global_clock_mc_index] && !$past(dual_mode_global_clock_level)) |-> glob_rise[1];
   endproperty
   a_dual_mode_global_clock_int: assert property (p_dual_mode_global_clock_int) // R4
      else $error("Internal equation did not clock the second global.");

   property p_ctclk;
      ($rose(ct_val[CT_CLK_A])) |-> ct_rise[0];
   endproperty
   a_ctclk: assert property (p_ctclk) // R11
      else $error("Control term two rise gave no clock strobe.");

   // Edges of the first global clock become strobes in the same cycle.
   property p_sync_rise;
      $rose(sync_global_clock) |-> glob_rise[0];
   endproperty
   a_sync_rise: assert property (p_sync_rise) // R3
      else $error("First global clock rise gave no strobe.");

   property p_sync_fall;
      (!$past(sys_rst) && $fell(sync_global_clock)) |-> glob_fall[0];
   endproperty
   a_sync_fall: assert property (p_sync_fall) // R5
      else $error("First global clock fall gave no strobe.");

   // Control terms of either kind, and terms from both arrays.
   property p_ct_kind;
      ((!ct_is_sum[4] && ct_val[4])
         |-> (ct_mask[4][N_IN-1:0] & ~central_interconnect_array) == '0)
      and ((ct_is_sum[5] && |(ct_mask[5][N_IN-1:0]
         & central_interconnect_array)) |-> ct_val[5]);
   endproperty
   a_ct_kind: assert property (p_ct_kind) // R7
      else $error("Control term does not act as its sum or product.");

   property p_pal;
      (|g_mc[3].pal_term) |-> mc_sum[3];
   endproperty
   a_pal: assert property (p_pal) // R17
      else $error("Dedicated product term did not reach its cell.");

   property p_share;
      (pla_term[0] && pla_or_mask[2][0] && pla_or_mask[3][0])
         |-> mc_sum[2] && mc_sum[3];
   endproperty
   a_share: assert property (p_share) // R18 R19
      else $error("Shared product term did not reach every cell.");

   // Main scenarios: tristate, internal clock and a shared term.
   c_gts: cover property (gts_enable && !global_tristate_pin);
   c_dual_mode_global_clock: cover property (dual_mode_global_clock_internal && glob_rise[1]);
   c_share: cover property (pla_term[0] && pla_or_mask[2][0]
                            && pla_or_mask[3][0]);

endmodule

`default_nettype wire

//--- dv/cpldlb_pin_model.sv
// Pin-side model: outside logic that shares the block's sixteen I/O pins.
// Assumes the bench sets what the outside drives and when it lets go.
`timescale 1ns/10ps
`default_nettype none

module cpldlb_pin_model (
   // Clock.
   input  wire logic        clock,
   // Block side of the pins.
   input  wire logic [15:0] pad_out,
   input  wire logic [15:0] pad_oe,
   // Outside drivers.
   input  wire logic [15:0] ext_val,
   input  wire logic [15:0] ext_drive,
   // Resolved pin level.
   output logic [15:0]      pad_in
);
   logic [15:0] last_level;

   // A pin that nobody drives shows the inverse of its last level.
   assign pad_in = (pad_oe & pad_out) | (~pad_oe & ext_drive & ext_val)
                 | (~pad_oe & ~ext_drive & ~last_level);

   // Remembers the last level so a floating pin cannot look settled.
   always_ff @(posedge clock) begin
      last_level <= pad_in;
   end
endmodule
`default_nettype wire

//--- dv/cpldlb_block_test.sv
// Bench for the logic block: configures cells, drives clocks and inputs.
// Assumes the pin model stands on the pins and one 125 MHz clock.
`timescale 1ns/10ps
`default_nettype none

module cpldlb_block_test;
   import cpldlb_pkg::*;

   logic clock = 1'b0;
   logic sys_rst = 1'b1;
   logic sgc = 1'b0, dgc = 1'b0, gpin = 1'b1;
   logic [NUM_INPUTS-1:0] ins = '0;
   logic [NUM_CT-1:0][NUM_LITERALS-1:0] ct_mask = '0;
   logic [NUM_CT-1:0] ct_is_sum = '0;
   logic [15:0][PAL_TERMS-1:0][NUM_LITERALS-1:0] pal_mask = '0;
   logic [PLA_TERMS-1:0][NUM_LITERALS-1:0] pla_mask = '0;
   logic [15:0][PLA_TERMS-1:0] pla_or_mask = '0;
   cpldlb_mode_t [15:0] mc_mode;
   cpldlb_clksel_t [15:0] mc_clk_sel;
   logic [15:0] mc_clk_falling = '0, mc_async_en = '0;
   logic [15:0][2:0] mc_oe_sel;
   logic dual_mode_global_clock_internal = 1'b0, gts_enable = 1'b0;
   logic [3:0] dual_mode_global_clock_mc_index = 4'h0;
   logic [15:0] pad_in, pad_out, pad_oe, mc_feedback, pin_feedback;
   logic [15:0] ext_val = '0, ext_drive = '0;
   logic [7:0] oe_exp = 8'h36;
   int num_errors = 0;
   int n_tests = 0;

   // Clock of 8 ns period.
   always #4 clock = ~clock;

   cpldlb_block dut (.clock(clock), .sys_rst(sys_rst),
      .sync_global_clock(sgc), .dual_mode_global_clock(dgc),
      .global_tristate_pin(gpin), .central_interconnect_array(ins),
      .ct_mask(ct_mask), .ct_is_sum(ct_is_sum), .pal_mask(pal_mask),
      .pla_mask(pla_mask), .pla_or_mask(pla_or_mask), .mc_mode(mc_mode),
      .mc_clk_sel(mc_clk_sel), .mc_clk_falling(mc_clk_falling),
      .mc_async_en(mc_async_en), .mc_oe_sel(mc_oe_sel),
      .dual_mode_global_clock_internal(dual_mode_global_clock_internal), .dual_mode_global_clock_mc_index(dual_mode_global_clock_mc_index),
      .gts_enable(gts_enable), .pad_in(pad_in), .pad_out(pad_out),
      .pad_oe(pad_oe), .mc_feedback(mc_feedback),
      .pin_feedback(pin_feedback));

   cpldlb_pin_model pins (.clock(clock), .pad_out(pad_out),
      .pad_oe(pad_oe), .ext_val(ext_val), .ext_drive(ext_drive),
      .pad_in(pad_in));

   // Waits for n rising edges, then steps just past the last one.
   task automatic tick(input int n);
      repeat (n) @(posedge clock);
      #1;
   endtask

   // Compares one seen value with its expected value.
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      n_tests++;
      if (seen !== exp) begin
         num_errors++;
         $display("wrong value at %0t ns: saw %h, expected %h", $time,
                  seen, exp);
      end
   endtask

   // Gives a rising then a falling edge on the first global clock.
   task automatic pulse();
      sgc = 1'b1;
      tick(3);
      sgc = 1'b0;
      tick(3);
   endtask

   // Prints the counts and the verdict, then ends the run.
   task automatic print_verdict();
      $display("checks %0d, mismatches %0d", n_tests, num_errors);
      if (num_errors == 0 && n_tests > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   // Cuts a hung run short and counts it as a mismatch.
   initial begin
      repeat (3000) @(posedge clock);
      num_errors++;
      print_verdict();
   end

   // Default configuration at time zero, then per-cell settings.
   initial begin
      for (int m = 0; m < 16; m++) begin
         mc_mode[m] = MC_COMB;
         mc_clk_sel[m] = CS_GLOBAL0;
         mc_oe_sel[m] = OE_ON;
      end
      mc_mode[0] = MC_DFF;
      mc_mode[1] = MC_TFF;
      mc_mode[4] = MC_DFF;
      mc_mode[6] = MC_DFF;
      mc_mode[7] = MC_DFF;
      mc_clk_falling[1] = 1'b1;
      mc_clk_sel[6] = CS_CT2;
      mc_clk_sel[7] = CS_GLOBAL1;
      mc_async_en[0] = 1'b1;
      pal_mask[0][0][0] = 1'b1;
      pal_mask[1][0][1] = 1'b1;
      pal_mask[2][0][2] = 1'b1;
      pal_mask[3][4][3+NUM_INPUTS] = 1'b1;
      pal_mask[4][0][0] = 1'b1;
      pal_mask[6][0][10] = 1'b1;
      pal_mask[7][0][12] = 1'b1;
      pla_mask[0][11] = 1'b1;
      pla_or_mask[2][0] = 1'b1;
      pla_or_mask[3][0] = 1'b1;
      for (int c = 0; c < NUM_CT; c++) begin
         ct_mask[c][c+4] = 1'b1;
      end
      ct_mask[4][13] = 1'b1;
      ct_is_sum = 6'h2F;
   end

   // Main sequence.
   initial begin
      tick(5);
      sys_rst = 1'b0;
      tick(1);
      check(pad_out & 16'h00D3, 16'h0000);
      $display("test reset done");
      ins[0] = 1'b1;
      sgc = 1'b1;
      tick(3);
      check(pad_out & 16'h0011, 16'h0011);
      check(mc_feedback & 16'h0001, 16'h0001);
      sgc = 1'b0;
      tick(3);
      check(pad_out & 16'h0002, 16'h0000);
      ins[1] = 1'b1;
      for (int k = 1; k < 4; k++) begin
         pulse();
         check(pad_out & 16'h0002, (k % 2) ? 16'h0002 : 16'h0000);
      end
      ins[1] = 1'b0;
      pulse();
      check(pad_out & 16'h0002, 16'h0002);
      $display("test flip-flops done");
      ins[2] = 1'b1;
      tick(1);
      check(pad_out & 16'h000C, 16'h000C);
      ins[2] = 1'b0;
      ins[3] = 1'b1;
      ins[11] = 1'b1;
      tick(1);
      check(pad_out & 16'h000C, 16'h000C);
      ins[11] = 1'b0;
      tick(1);
      check(pad_out & 16'h000C, 16'h0000);
      ins[3] = 1'b0;
      $display("test product terms done");
      ins[0] = 1'b0;
      pulse();
      ins[4] = 1'b1;
      tick(1);
      check(pad_out & 16'h0011, 16'h0001);
      pulse();
      check(pad_out & 16'h0001, 16'h0001);
      ins[5] = 1'b1;
      tick(1);
      check(pad_out & 16'h0001, 16'h0000);
      ins[4] = 1'b0;
      ins[5] = 1'b0;
      tick(2);
      check(pad_out & 16'h0001, 16'h0000);
      $display("test preset and clear done");
      ins[9:6] = 4'hD;
      ins[13] = 1'b1;
      for (int c = 0; c < 8; c++) begin
         mc_oe_sel[5] = c[2:0];
         tick(1);
         check(pad_oe & 16'h0020, {10'h0, oe_exp[c], 5'h0});
      end
      mc_oe_sel[5] = OE_CT4;
      ins[13] = 1'b0;
      tick(1);
      check(pad_oe & 16'h0020, 16'h0000);
      gpin = 1'b0;
      tick(1);
      check(pad_oe, 16'hFFDF);
      gts_enable = 1'b1;
      tick(1);
      check(pad_oe, 16'h0000);
      gpin = 1'b1;
      tick(1);
      check(pad_oe, 16'hFFDF);
      $display("test output enables done");
      ins[6] = 1'b0;
      ins[10] = 1'b1;
      tick(3);
      check(pad_out & 16'h0040, 16'h0000);
      ins[6] = 1'b1;
      tick(3);
      check(pad_out & 16'h0040, 16'h0040);
      ins[12] = 1'b1;
      dgc = 1'b1;
      tick(3);
      check(pad_out & 16'h0080, 16'h0080);
      dual_mode_global_clock_internal = 1'b1;
      dual_mode_global_clock_mc_index = 4'h2;
      ins[12] = 1'b0;
      dgc = 1'b0;
      tick(3);
      check(pad_out & 16'h0080, 16'h0080);
      ins[2] = 1'b1;
      tick(3);
      check(pad_out & 16'h0080, 16'h0000);
      $display("test clock sources done");
      mc_oe_sel[8] = OE_OFF;
      ext_drive[8] = 1'b1;
      ext_val[8] = 1'b1;
      tick(1);
      check(pin_feedback & 16'h0100, 16'h0100);
      check(mc_feedback & 16'h0100, 16'h0000);
      ext_val[8] = 1'b0;
      tick(1);
      check(pin_feedback & 16'h0100, 16'h0000);
      $display("test pin feedback done");
      print_verdict();
   end
endmodule
`default_nettype wire
